// ---- hw/rgs_pkg.sv ----
// package for the register gating slice: widths, encodings and carriers.
// assumes one clock domain; the slice is a 4-bit cut of a wider datapath.
package rgs_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned SLICE_W = 4;

  // ----------------------------------------------------------------
  // operand gate encodings
  // ----------------------------------------------------------------
  localparam logic POL_TRUE_LEVEL  = 1'h0;
  localparam logic FORCE_LVL_POL_0 = 1'h0;
  localparam logic FORCE_LVL_POL_1 = 1'h1;

  // ----------------------------------------------------------------
  // both-low combining function codes
  // ----------------------------------------------------------------
  localparam logic [1:0] COMB_OR  = 2'h0;
  localparam logic [1:0] COMB_AND = 2'h1;
  localparam logic [1:0] COMB_XOR = 2'h2;
  localparam logic [1:0] COMB_SEC = 2'h3;
  localparam logic [7:0] COMB_DEFAULT = {COMB_OR, COMB_OR, COMB_OR, COMB_OR};

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [SLICE_W-1:0] DATA_RST  = 4'h0;
  localparam logic               CARRY_RST = 1'h0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic force_en;
    logic polarity;
  } rgs_gate_ctl_t;

  typedef struct packed {
    logic sel_c;
    logic sel_d;
  } rgs_mux_ctl_t;

  typedef struct packed {
    logic [SLICE_W-1:0] sum;
    logic               carry;
  } rgs_add_res_t;

endpackage

// ---- hw/rgs_mux_bit.sv ----
// one bit position of the dual-input data-line multiplexer.
// assumes controls are shared by all positions of the slice.
`timescale 1ns/10ps
module rgs_mux_bit #(
  parameter logic [1:0] COMB_FN = rgs_pkg::COMB_OR
) (
  // controls
  input  wire rgs_pkg::rgs_mux_ctl_t ctl,
  // data
  input  wire logic                  first_input,
  input  wire logic                  second_input,
  // result
  output logic                       y
);

  wire logic both_low;
  wire logic comb_val;

  assign comb_val = (COMB_FN == rgs_pkg::COMB_AND) ? (first_input & second_input) :
                    (COMB_FN == rgs_pkg::COMB_XOR) ? (first_input ^ second_input) :
                    (COMB_FN == rgs_pkg::COMB_SEC) ? second_input :
                                                     (first_input | second_input);
  assign both_low = ~ctl.sel_c & ~ctl.sel_d;

  always_comb
  begin
    if (both_low)
      y = comb_val;
    else if (ctl.sel_c & ctl.sel_d)
      y = 1'b1;
    else if (ctl.sel_c)
      y = first_input;
    else
      y = second_input;
  end

endmodule

// ---- hw/rgs_slice.sv ----
// 4-bit register gating slice: operand gate, adder and data-line multiplexer.
// assumes synchronous inputs; results are registered, the ripple carry is not.
`timescale 1ns/10ps
module rgs_slice #(
  parameter logic       POL_TRUE  = rgs_pkg::POL_TRUE_LEVEL,
  parameter logic       FORCE_P0  = rgs_pkg::FORCE_LVL_POL_0,
  parameter logic       FORCE_P1  = rgs_pkg::FORCE_LVL_POL_1,
  parameter logic [7:0] COMB_FNS  = rgs_pkg::COMB_DEFAULT
) (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  // operand gate
  input  wire rgs_pkg::rgs_gate_ctl_t         gate_ctl,
  input  wire logic [rgs_pkg::SLICE_W-1:0]    gate_in,
  output logic      [rgs_pkg::SLICE_W-1:0]    gate_out,
  // adder
  input  wire logic [rgs_pkg::SLICE_W-1:0]    add_a,
  input  wire logic                           carry_in,
  output rgs_pkg::rgs_add_res_t               add_res,
  output logic                                carry_chain_out,
  // data-line multiplexer
  input  wire rgs_pkg::rgs_mux_ctl_t          mux_ctl,
  input  wire logic [rgs_pkg::SLICE_W-1:0]    first_input,
  input  wire logic [rgs_pkg::SLICE_W-1:0]    second_input,
  output logic      [rgs_pkg::SLICE_W-1:0]    mux_out
);

  // ----------------------------------------------------------------
  // operand gate
  // ----------------------------------------------------------------
  // one control pair serves every position, so the level picks are shared
  wire logic                        force_lvl;
  wire logic                        want_true;
  wire logic [rgs_pkg::SLICE_W-1:0] true_data;
  wire logic [rgs_pkg::SLICE_W-1:0] cmpl_data;
  wire logic [rgs_pkg::SLICE_W-1:0] next_gate;

  assign force_lvl = gate_ctl.polarity ? FORCE_P1 : FORCE_P0;
  assign want_true = (gate_ctl.polarity == POL_TRUE);

  for (genvar i = 0; i < rgs_pkg::SLICE_W; i++)
  begin : g_gate
    assign true_data[i] = gate_in[i];
    assign cmpl_data[i] = ~gate_in[i];
    // force wins over data, so a forced slice ignores its data pins; polarity picks the forced level
    assign next_gate[i] = gate_ctl.force_en ? force_lvl :
                          (want_true ? true_data[i] : cmpl_data[i]);
  end

  // ----------------------------------------------------------------
  // adder
  // ----------------------------------------------------------------
  // the gated operand is the adder's second term, as in the register path
  wire logic [rgs_pkg::SLICE_W-1:0] bit_gen;
  wire logic [rgs_pkg::SLICE_W-1:0] bit_prop;
  wire logic [rgs_pkg::SLICE_W-1:0] bit_sum;
  wire logic [rgs_pkg::SLICE_W:0]   ripple;
  wire rgs_pkg::rgs_add_res_t       next_res;

  assign ripple[0] = carry_in;

  for (genvar i = 0; i < rgs_pkg::SLICE_W; i++)
  begin : g_add
    assign bit_gen[i]    = add_a[i] & next_gate[i];
    assign bit_prop[i]   = add_a[i] ^ next_gate[i];
    assign bit_sum[i]    = bit_prop[i] ^ ripple[i];
    assign ripple[i + 1] = bit_gen[i] | (bit_prop[i] & ripple[i]);
  end

  assign next_res = '{sum: bit_sum, carry: ripple[rgs_pkg::SLICE_W]};
  // left combinational so a chain of slices settles in one cycle
  assign carry_chain_out = ripple[rgs_pkg::SLICE_W];

  // ----------------------------------------------------------------
  // multiplexer
  // ----------------------------------------------------------------
  wire logic [rgs_pkg::SLICE_W-1:0] next_mux;

  for (genvar i = 0; i < rgs_pkg::SLICE_W; i++)
  begin : g_mux
    rgs_mux_bit #(
      .COMB_FN (COMB_FNS[2*i +: 2])
    ) u_bit (
      .ctl          (mux_ctl),
      .first_input  (first_input[i]),
      .second_input (second_input[i]),
      .y            (next_mux[i])
    );
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      gate_out <= rgs_pkg::DATA_RST;
    else
      gate_out <= next_gate;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      add_res <= '{sum: rgs_pkg::DATA_RST, carry: rgs_pkg::CARRY_RST};
    else
      add_res <= next_res;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mux_out <= rgs_pkg::DATA_RST;
    else
      mux_out <= next_mux;
  end

endmodule

// ---- verif/rgs_slice_sva.sv ----
// checker for the gating slice, bound to its ports.
// assumes one clock; registered outputs trail inputs by one edge.
`timescale 1ns/10ps
module rgs_slice_sva (
  input wire logic clk, rst_n, carry_in, carry_chain_out,
  input wire rgs_pkg::rgs_gate_ctl_t gate_ctl,
  input wire rgs_pkg::rgs_mux_ctl_t  mux_ctl,
  input wire rgs_pkg::rgs_add_res_t  add_res,
  input wire logic [3:0] gate_in, gate_out, add_a, first_input, second_input, mux_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  gate_data_a: assert property ($past(rst_n) && !$past(gate_ctl.force_en) |->
    gate_out == ($past(gate_ctl.polarity) ? ~$past(gate_in) : $past(gate_in))) else $error("gate data");
  gate_force_a: assert property ($past(rst_n) && $past(gate_ctl.force_en) |->
    gate_out == {4{$past(gate_ctl.polarity)}}) else $error("gate force");
  add_sum_a: assert property ($past(rst_n) |->
    {add_res.carry, add_res.sum} == 5'($past(add_a)) + 5'(gate_out) + 5'($past(carry_in))) else $error("sum");
  carry_link_a: assert property (rst_n |=> add_res.carry == $past(carry_chain_out))
    else $error("carry");
  mux_both_a: assert property ($past(rst_n) && $past(mux_ctl) == 2'h0 |->
    mux_out == ($past(first_input) | $past(second_input))) else $error("mux both");
  mux_second_a: assert property ($past(rst_n) && $past(mux_ctl) == 2'h1 |->
    mux_out == $past(second_input)) else $error("mux second");
  mux_first_a: assert property ($past(rst_n) && $past(mux_ctl) == 2'h2 |->
    mux_out == $past(first_input)) else $error("mux first");
  mux_ones_a: assert property ($past(rst_n) && $past(mux_ctl) == 2'h3 |-> mux_out == 4'hf)
    else $error("mux ones");
  force_c: cover property (gate_ctl.force_en);
  ones_c: cover property (mux_ctl == 2'h3);
  carry_c: cover property (add_res.carry);
endmodule
bind rgs_slice rgs_slice_sva chk (.clk(clk), .rst_n(rst_n), .gate_ctl(gate_ctl), .gate_in(gate_in),
  .gate_out(gate_out), .add_a(add_a), .carry_in(carry_in), .add_res(add_res), .carry_chain_out(carry_chain_out),
  .mux_ctl(mux_ctl), .first_input(first_input), .second_input(second_input), .mux_out(mux_out));

// ---- verif/rgs_low_slice.sv ----
// far side: the less significant slice feeding the carry in.
// assumes its operands come from the bench.
`timescale 1ns/10ps
module rgs_low_slice (
  input  wire logic [3:0] lo_a,
  input  wire logic [3:0] lo_b,
  output logic            carry
);
  assign carry = 5'(lo_a) + 5'(lo_b) > 5'h0f;
endmodule

// ---- verif/register_gating_slice_test.sv ----
// bench for the gating slice, a lower slice feeding its carry.
// assumes registered outputs settle one edge after their inputs; the ripple carry settles in the same cycle.
`timescale 1ns/10ps
module register_gating_slice_test;
  logic clk = 1'h0, rst_n = 1'h0, ci, cc;
  rgs_pkg::rgs_gate_ctl_t gc = '0;
  rgs_pkg::rgs_mux_ctl_t mc = '0;
  rgs_pkg::rgs_add_res_t ar;
  logic [3:0] gi = '0, a = '0, f = '0, s = '0, la = '0, lb = '0, go, mo;
  logic [31:0] rnd = 32'heb6a_0b2f;
  logic [12:0] q[$];
  int n_fail = 0, cmp_count = 0;
  always #20 clk = ~clk;
  rgs_low_slice lo (.lo_a(la), .lo_b(lb), .carry(ci));
  rgs_slice uut (.clk(clk), .rst_n(rst_n), .gate_ctl(gc), .gate_in(gi), .gate_out(go), .add_a(a),
    .carry_in(ci), .add_res(ar), .carry_chain_out(cc), .mux_ctl(mc), .first_input(f), .second_input(s),
    .mux_out(mo));
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  // m holds {mux_ctl, gate_ctl}; r the random data word
  function automatic logic [12:0] model(logic [3:0] m, logic [31:0] r);
    logic [3:0] g, y;
    logic [4:0] t;
    g = m[1] ? {4{m[0]}} : (m[0] ? ~r[3:0] : r[3:0]);
    t = 5'(r[7:4]) + 5'(g) + 5'(5'(r[19:16]) + 5'(r[23:20]) > 5'h0f);
    y = m[3] ? (m[2] ? 4'hf : r[11:8]) : (m[2] ? r[15:12] : r[11:8] | r[15:12]);
    return {g, t[3:0], t[4], y};
  endfunction
  task automatic check(logic [12:0] seen, logic [12:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic run(int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      rnd = xs(rnd);
      {mc, gc} <= i[3:0];
      {lb, la, s, f, a, gi} <= rnd[23:0];
      q.push_back(model(i[3:0], rnd));
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one edge of lag: the oldest note matches what the last edge captured
  // the ripple carry is combinational, so it answers the newest note
  always @(negedge clk)
    if (rst_n && q.size() > 0)
    begin
      check(13'(cc), 13'(q[$][4]));
      if (q.size() > 1)
        check({go, ar, mo}, q.pop_front());
    end
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    run(64);
    $display("sweep done");
    @(posedge clk);
    rst_n <= 1'h0;
    @(negedge clk);
    q.delete();
    check({go, ar, mo}, 13'h0);
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    run(32);
    repeat (2) @(posedge clk);
    $display("reset test done");
    test_done;
  end
endmodule
